//--- core/host_port_reset_boot_consts.svh
// Constants for the host port, reset and boot control block.
// Assumes a 200 MHz sys_clk; included by the host_port_reset_boot module.
// Function
// - Above 100 kHz bus rate the device stretches the serial clock low for wait states.
// - One target address bit comes from the address-select pin; floating is allowed.
// - In 4-wire SPI mode the shared pin carries serial read data.
// - In 3-wire SPI mode the shared pin becomes the fourth general I/O.
// - Each of three general pins is input or output per configuration.
// - Reset acts only when the reset pin stays low for the minimum width.
// - Reset returns to a known state and reloads plan and image from memory.
// - All output clocks stop while the reset input is held asserted.
// - With no stored plan, reset enters a bootloader state awaiting host download.
// - In I2C operation the data pin is bidirectional between host and device.
`ifndef HOST_PORT_RESET_BOOT_CONSTS_SVH
`define HOST_PORT_RESET_BOOT_CONSTS_SVH
`define CLK_PERIOD_PS 5000
`define RST_MIN_WIDTH_NS 1000
`define RST_MIN_CYCLES ((`RST_MIN_WIDTH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define STRETCH_RATE_KHZ 100
`define STRETCH_CYCLES 16
`define I2C_ADDR_BASE 7'h68
`define I2C_ADDR_SEL_BIT 0
`define LOAD_WORDS 8
`endif

//--- core/host_port_reset_boot_pkg.sv
// Types for the host port, reset and boot control block.
// Assumes the constants header is available on the include path.
package host_port_reset_boot_pkg;
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_LOAD = 3'b001,
    ST_RUN = 3'b010,
    ST_BOOT = 3'b011,
    ST_DOWNLOAD = 3'b100
  } boot_state_t;
endpackage : host_port_reset_boot_pkg

//--- core/pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes sys_clk domain, synchronous active-low reset.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Levels.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    if (!rst_b) begin
      // Keep sampling through reset so that straps are valid as soon as it lifts.
      nxt_meta = async_in;
      nxt_sync = meta_ff;
    end else if (clk_en) begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign sync_out = sync_ff;
endmodule : pin_sync

//--- core/host_port_reset_boot.sv
// Host port pin control, pin reset qualification and boot sequencing.
// Assumes sys_clk at 200 MHz; pins come from outside and are synchronised here.
`timescale 1ns/10ps
`include "host_port_reset_boot_consts.svh"
module host_port_reset_boot #(
  parameter int RST_MIN_CYCLES = `RST_MIN_CYCLES,
  parameter int STRETCH_CYCLES = `STRETCH_CYCLES,
  parameter int LOAD_WORDS = `LOAD_WORDS,
  parameter int IO_COUNT = 3
) (
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Device reset pin, undriven reads as high.
  input wire logic device_reset_n,
  input wire logic device_reset_n_driven,
  // Serial host port pins.
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic address_select_or_chip_select,
  input wire logic address_select_driven,
  // Serial engine side.
  input wire logic spi_mode,
  input wire logic spi_four_wire,
  input wire logic fast_rate,
  input wire logic engine_busy,
  input wire logic engine_sda_low,
  input wire logic spi_read_data,
  input wire logic spi_read_active,
  output logic scl_sync,
  output logic sda_sync,
  output logic [6:0] target_address,
  // Shared data-out / auxiliary pin.
  input wire logic shared_data_out_or_aux_io_in,
  output logic shared_data_out_or_aux_io_out,
  output logic shared_data_out_or_aux_io_oe_n,
  // General I/O pins.
  input wire logic [IO_COUNT-1:0] general_io_in,
  output logic [IO_COUNT-1:0] general_io_out,
  output logic [IO_COUNT-1:0] general_io_oe_n,
  input wire logic [IO_COUNT:0] io_dir_out,
  input wire logic [IO_COUNT:0] io_drive_value,
  output logic [IO_COUNT:0] io_sampled,
  // Non-volatile memory loader.
  input wire logic nvm_plan_valid,
  output logic nvm_read_req,
  input wire logic nvm_read_ack,
  input wire logic [31:0] nvm_read_data,
  output logic [31:0] load_data,
  output logic load_strobe,
  // Host download path in bootloader state.
  input wire logic host_load_valid,
  input wire logic [31:0] host_load_data,
  input wire logic host_load_done,
  // Device state.
  output logic clocks_enable,
  output logic in_bootloader,
  output logic device_reset_active
);
  localparam int RST_W = $clog2(RST_MIN_CYCLES + 1);
  localparam int STR_W = $clog2(STRETCH_CYCLES + 1);
  localparam int LD_W = $clog2(LOAD_WORDS + 1);

  logic [IO_COUNT:0] pins_raw;
  logic [IO_COUNT+4:0] sync_bus;
  logic rst_pin_s;
  logic addr_sel_s;
  logic rst_level;

  // A floating reset pin reads as deasserted, like an internal pull-up.
  assign rst_level = device_reset_n_driven ? device_reset_n : 1'b1;
  assign pins_raw = {shared_data_out_or_aux_io_in, general_io_in};

  pin_sync #(
    .WIDTH(IO_COUNT + 5)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({rst_level, scl_in, sda_in,
      address_select_driven & address_select_or_chip_select, pins_raw}),
    .sync_out(sync_bus)
  );

  assign rst_pin_s = sync_bus[IO_COUNT+4];
  assign scl_sync = sync_bus[IO_COUNT+3];
  assign sda_sync = sync_bus[IO_COUNT+2];
  assign addr_sel_s = sync_bus[IO_COUNT+1];
  assign io_sampled = sync_bus[IO_COUNT:0];

  // Reset pin qualification: low must last the minimum width.
  logic [RST_W-1:0] low_cnt_ff;
  logic [RST_W-1:0] nxt_low_cnt;
  logic reset_hold_ff;
  logic nxt_reset_hold;

  always_comb begin
    nxt_low_cnt = low_cnt_ff;
    nxt_reset_hold = reset_hold_ff;
    if (!rst_b) begin
      nxt_low_cnt = '0;
      nxt_reset_hold = 1'b0;
    end else if (clk_en) begin
      if (rst_pin_s) begin
        nxt_low_cnt = '0;
        nxt_reset_hold = 1'b0;
      end else if (low_cnt_ff != RST_W'(RST_MIN_CYCLES)) begin
        nxt_low_cnt = low_cnt_ff + RST_W'(1);
      end else begin
        nxt_reset_hold = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    low_cnt_ff <= nxt_low_cnt;
    reset_hold_ff <= nxt_reset_hold;
  end

  // Boot sequencer.
  host_port_reset_boot_pkg::boot_state_t state_ff;
  host_port_reset_boot_pkg::boot_state_t nxt_state;
  logic [LD_W-1:0] word_cnt_ff;
  logic [LD_W-1:0] nxt_word_cnt;
  logic [31:0] load_data_ff;
  logic [31:0] nxt_load_data;
  logic load_strobe_ff;
  logic nxt_load_strobe;
  logic [6:0] addr_ff;
  logic [6:0] nxt_addr;

  always_comb begin
    nxt_state = state_ff;
    nxt_word_cnt = word_cnt_ff;
    nxt_load_data = load_data_ff;
    nxt_load_strobe = load_strobe_ff;
    nxt_addr = addr_ff;
    if (!rst_b) begin
      nxt_state = host_port_reset_boot_pkg::ST_RESET;
      nxt_word_cnt = '0;
      nxt_load_data = 32'h0000_0000;
      nxt_load_strobe = 1'b0;
      nxt_addr = `I2C_ADDR_BASE;
    end else if (clk_en) begin
      nxt_load_strobe = 1'b0;
      if (reset_hold_ff) begin
        nxt_state = host_port_reset_boot_pkg::ST_RESET;
        nxt_word_cnt = '0;
      end else begin
        case (state_ff)
          host_port_reset_boot_pkg::ST_RESET: begin
            // The address bit is caught once the device leaves reset.
            nxt_addr = `I2C_ADDR_BASE;
            nxt_addr[`I2C_ADDR_SEL_BIT] = addr_sel_s;
            nxt_word_cnt = '0;
            if (nvm_plan_valid) begin
              nxt_state = host_port_reset_boot_pkg::ST_LOAD;
            end else begin
              nxt_state = host_port_reset_boot_pkg::ST_BOOT;
            end
          end
          host_port_reset_boot_pkg::ST_LOAD: begin
            if (nvm_read_ack) begin
              nxt_load_data = nvm_read_data;
              nxt_load_strobe = 1'b1;
              nxt_word_cnt = word_cnt_ff + LD_W'(1);
              if (word_cnt_ff == LD_W'(LOAD_WORDS - 1)) begin
                nxt_state = host_port_reset_boot_pkg::ST_RUN;
              end
            end
          end
          host_port_reset_boot_pkg::ST_RUN: begin
            nxt_state = host_port_reset_boot_pkg::ST_RUN;
          end
          host_port_reset_boot_pkg::ST_BOOT: begin
            if (host_load_valid) begin
              nxt_state = host_port_reset_boot_pkg::ST_DOWNLOAD;
              nxt_load_data = host_load_data;
              nxt_load_strobe = 1'b1;
            end
          end
          host_port_reset_boot_pkg::ST_DOWNLOAD: begin
            if (host_load_valid) begin
              nxt_load_data = host_load_data;
              nxt_load_strobe = 1'b1;
            end
            if (host_load_done) begin
              nxt_state = host_port_reset_boot_pkg::ST_RUN;
            end
          end
          default: begin
            nxt_state = host_port_reset_boot_pkg::ST_RESET;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    state_ff <= nxt_state;
    word_cnt_ff <= nxt_word_cnt;
    load_data_ff <= nxt_load_data;
    load_strobe_ff <= nxt_load_strobe;
    addr_ff <= nxt_addr;
  end

  assign nvm_read_req = (state_ff == host_port_reset_boot_pkg::ST_LOAD) && !reset_hold_ff;
  assign load_data = load_data_ff;
  assign load_strobe = load_strobe_ff;
  assign target_address = addr_ff;
  assign in_bootloader = (state_ff == host_port_reset_boot_pkg::ST_BOOT) ||
    (state_ff == host_port_reset_boot_pkg::ST_DOWNLOAD);
  // Output clocks run only once a plan is in place and no reset is held.
  assign clocks_enable = (state_ff == host_port_reset_boot_pkg::ST_RUN) &&
    rst_pin_s && !reset_hold_ff;
  assign device_reset_active = reset_hold_ff;

  // Clock stretching: hold SCL low for up to STRETCH_CYCLES cycles while the engine is busy at fast rates.
  logic [STR_W-1:0] str_cnt_ff;
  logic [STR_W-1:0] nxt_str_cnt;
  logic scl_low_ff;
  logic nxt_scl_low;
  logic sda_low_ff;
  logic nxt_sda_low;
  logic [IO_COUNT:0] io_out_ff;
  logic [IO_COUNT:0] nxt_io_out;
  logic [IO_COUNT:0] io_oe_n_ff;
  logic [IO_COUNT:0] nxt_io_oe_n;
  logic aux_mode;

  assign aux_mode = !(spi_mode && spi_four_wire);

  always_comb begin
    nxt_str_cnt = str_cnt_ff;
    nxt_scl_low = scl_low_ff;
    nxt_sda_low = sda_low_ff;
    nxt_io_out = io_out_ff;
    nxt_io_oe_n = io_oe_n_ff;
    if (!rst_b) begin
      nxt_str_cnt = '0;
      nxt_scl_low = 1'b0;
      nxt_sda_low = 1'b0;
      nxt_io_out = '0;
      nxt_io_oe_n = '1;
    end else if (clk_en) begin
      nxt_scl_low = 1'b0;
      if (!spi_mode && fast_rate && engine_busy &&
          str_cnt_ff != STR_W'(STRETCH_CYCLES)) begin
        nxt_scl_low = 1'b1;
        nxt_str_cnt = str_cnt_ff + STR_W'(1);
      end else if (!engine_busy) begin
        nxt_str_cnt = '0;
      end
      nxt_sda_low = !spi_mode && engine_sda_low && !reset_hold_ff;
      nxt_io_out = io_drive_value;
      nxt_io_oe_n = ~io_dir_out;
      if (!aux_mode) begin
        nxt_io_out[IO_COUNT] = spi_read_data;
        nxt_io_oe_n[IO_COUNT] = !spi_read_active;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    str_cnt_ff <= nxt_str_cnt;
    scl_low_ff <= nxt_scl_low;
    sda_low_ff <= nxt_sda_low;
    io_out_ff <= nxt_io_out;
    io_oe_n_ff <= nxt_io_oe_n;
  end

  assign scl_out = 1'b0;
  assign scl_oe_n = !scl_low_ff;
  assign sda_out = 1'b0;
  assign sda_oe_n = !sda_low_ff;
  assign general_io_out = io_out_ff[IO_COUNT-1:0];
  assign general_io_oe_n = io_oe_n_ff[IO_COUNT-1:0];
  // In 3-wire mode the shared pin follows the fourth general I/O setting.
  assign shared_data_out_or_aux_io_out = io_out_ff[IO_COUNT];
  assign shared_data_out_or_aux_io_oe_n = io_oe_n_ff[IO_COUNT];
endmodule : host_port_reset_boot

//--- tb/host_port_reset_boot_monitor.sv
// Checker for the host port, reset and boot block.
// Assumes binding to the top module ports and clk_en held high.
`timescale 1ns/10ps
module host_port_reset_boot_monitor #(
  parameter int RST_MIN_CYCLES = 200,
  parameter int IO_COUNT = 3
) (
  // Clock, reset and pins.
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic device_reset_n,
  input wire logic device_reset_n_driven,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic spi_mode,
  input wire logic spi_four_wire,
  input wire logic fast_rate,
  input wire logic engine_busy,
  input wire logic engine_sda_low,
  input wire logic spi_read_data,
  input wire logic spi_read_active,
  input wire logic shared_data_out_or_aux_io_out,
  input wire logic shared_data_out_or_aux_io_oe_n,
  input wire logic [IO_COUNT-1:0] general_io_oe_n,
  input wire logic [IO_COUNT:0] io_dir_out,
  // Loader and state.
  input wire logic nvm_read_req,
  input wire logic nvm_read_ack,
  input wire logic load_strobe,
  input wire logic host_load_valid,
  input wire logic [31:0] nvm_read_data,
  input wire logic [31:0] load_data,
  input wire logic [31:0] host_load_data,
  input wire logic in_bootloader,
  input wire logic clocks_enable,
  input wire logic device_reset_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire pin_lo = !device_reset_n && device_reset_n_driven;
  logic [15:0] lo_cnt_ff, nxt_lo_cnt;
  always_comb nxt_lo_cnt = pin_lo ? lo_cnt_ff + 16'h0001 : 16'h0000;
  always_ff @(posedge sys_clk) lo_cnt_ff <= rst_b ? nxt_lo_cnt : 16'h0000;
  sequence s_pin_low; pin_lo [*3]; endsequence
  sequence s_ack; nvm_read_req && nvm_read_ack; endsequence
  property p_stretch; clk_en && !scl_oe_n |-> $past(engine_busy && fast_rate && !spi_mode);
  endproperty
  property p_sda; clk_en && !spi_mode && !device_reset_active |=>
    sda_oe_n == !$past(engine_sda_low); endproperty
  property p_sdo; clk_en && spi_mode && spi_four_wire |=> shared_data_out_or_aux_io_out ==
    $past(spi_read_data) && shared_data_out_or_aux_io_oe_n == !$past(spi_read_active);
  endproperty
  property p_aux; clk_en && spi_mode && !spi_four_wire |=>
    shared_data_out_or_aux_io_oe_n == !$past(io_dir_out[IO_COUNT]); endproperty
  property p_gio; clk_en |=> general_io_oe_n == ~$past(io_dir_out[IO_COUNT-1:0]); endproperty
  property p_width; $rose(device_reset_active) |-> $past(lo_cnt_ff, 2) >= RST_MIN_CYCLES;
  endproperty
  property p_load; s_ack |=> load_strobe && load_data == $past(nvm_read_data); endproperty
  property p_stop; s_pin_low |-> !clocks_enable; endproperty
  property p_boot; in_bootloader && host_load_valid && !device_reset_active |=>
    load_strobe && load_data == $past(host_load_data); endproperty
  a_stretch: assert property (p_stretch) else $error("scl held without cause");
  a_sda: assert property (p_sda) else $error("sda drive wrong");
  a_sdo: assert property (p_sdo) else $error("shared pin not read data");
  a_aux: assert property (p_aux) else $error("shared pin not aux io");
  a_gio: assert property (p_gio) else $error("io direction wrong");
  a_width: assert property (p_width) else $error("reset on short pulse");
  a_load: assert property (p_load) else $error("nvm word not loaded");
  a_stop: assert property (p_stop) else $error("clocks run in reset");
  a_boot: assert property (p_boot) else $error("download word lost");
endmodule : host_port_reset_boot_monitor

//--- tb/host_ctrl_model.sv
// Host controller model: bus pull-ups, reset pin and download.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/10ps
module host_ctrl_model #(
  parameter int GAP = 30
) (
  input wire logic sys_clk, scl_oe_n, sda_oe_n,
  output logic scl_in, sda_in, device_reset_n, device_reset_n_driven,
  output logic host_load_valid, host_load_done,
  output logic [31:0] host_load_data
);
  logic host_sda_n = 1'b1;
  // Pulled-up open-drain lines: whoever pulls low wins.
  assign scl_in = scl_oe_n;
  assign sda_in = sda_oe_n & host_sda_n;
  initial begin
    device_reset_n = 1'b1;
    device_reset_n_driven = 1'b0;
    host_load_valid = 1'b0;
    host_load_done = 1'b0;
    host_load_data = 32'h0000_0000;
  end
  task automatic sda_drive(input logic v);
    @(posedge sys_clk) host_sda_n <= v;
  endtask : sda_drive
  task automatic reset_pulse(input int n, input logic drv);
    @(posedge sys_clk);
    device_reset_n <= 1'b0;
    device_reset_n_driven <= drv;
    repeat (n) @(posedge sys_clk);
    device_reset_n <= 1'b1;
    device_reset_n_driven <= 1'b0;
    repeat (GAP) @(posedge sys_clk);
  endtask : reset_pulse
  task automatic download(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      host_load_valid <= 1'b1;
      host_load_data <= 32'hB007_0000 + 32'(i);
    end
    @(posedge sys_clk);
    host_load_valid <= 1'b0;
    host_load_data <= 32'h4FF8_FFFF;
    host_load_done <= 1'b1;
    @(posedge sys_clk) host_load_done <= 1'b0;
  endtask : download
endmodule : host_ctrl_model

//--- tb/host_port_reset_boot_tb.sv
// Self-checking bench for the host port, reset and boot block.
// Assumes the host model and checker files compile first.
`timescale 1ns/10ps
module host_port_reset_boot_tb;
  logic sys_clk, rst_b, clk_en, device_reset_n, device_reset_n_driven, scl_in, scl_out;
  logic scl_oe_n, sda_in, sda_out, sda_oe_n, address_select_or_chip_select;
  logic address_select_driven, spi_mode, spi_four_wire, fast_rate, engine_busy;
  logic engine_sda_low, spi_read_data, spi_read_active, scl_sync, sda_sync;
  logic shared_data_out_or_aux_io_in, shared_data_out_or_aux_io_out;
  logic shared_data_out_or_aux_io_oe_n, nvm_plan_valid, nvm_read_req, nvm_read_ack;
  logic load_strobe, host_load_valid, host_load_done, clocks_enable, in_bootloader;
  logic device_reset_active;
  logic [6:0] target_address;
  logic [2:0] general_io_in, general_io_out, general_io_oe_n;
  logic [3:0] io_dir_out, io_drive_value, io_sampled;
  logic [31:0] nvm_read_data, load_data, host_load_data;
  int bad_count = 0, check_count = 0, strobes = 0, acts = 0, offs = 0;
  host_port_reset_boot #(.RST_MIN_CYCLES(4)) u_host_port_reset_boot (.*);
  host_ctrl_model u_host_ctrl_model (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    nvm_read_ack <= nvm_read_req;
    if (!rst_b) nvm_read_data <= 32'h0000_0000;
    else if (nvm_read_ack) nvm_read_data <= nvm_read_data + 32'h0000_0001;
    if (load_strobe === 1'b1) strobes <= strobes + 1;
    if (device_reset_active === 1'b1) acts <= acts + 1;
    if (clocks_enable !== 1'b1) offs <= offs + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic t_start(input logic [6:0] addr);
    int b;
    b = strobes;
    cyc(20);
    check(strobes - b, 8);
    check(clocks_enable, 1'b1);
    check(target_address, addr);
  endtask : t_start
  task automatic t_serial();
    @(posedge sys_clk) {fast_rate, engine_busy, engine_sda_low} <= 3'b111;
    cyc(2);
    check(scl_in, 1'b0);
    check(sda_in, 1'b0);
    check({scl_out, sda_out}, 2'b00);
    cyc(20);
    check(scl_in, 1'b1);
    @(posedge sys_clk) {fast_rate, engine_sda_low} <= 2'b00;
    u_host_ctrl_model.sda_drive(1'b0);
    cyc(4);
    check({scl_in, scl_sync, sda_sync}, 3'b110);
    u_host_ctrl_model.sda_drive(1'b1);
    @(posedge sys_clk) {spi_mode, spi_four_wire, spi_read_active, spi_read_data} <= 4'hF;
    cyc(2);
    check({shared_data_out_or_aux_io_out, shared_data_out_or_aux_io_oe_n}, 2'b10);
    @(posedge sys_clk) {spi_four_wire, io_dir_out, io_drive_value} <= 9'h059;
    {shared_data_out_or_aux_io_in, general_io_in} <= 4'hB;
    cyc(4);
    check({shared_data_out_or_aux_io_out, shared_data_out_or_aux_io_oe_n}, 2'b11);
    check({general_io_oe_n, general_io_out[0]}, 4'h5);
    check(io_sampled, 4'hB);
  endtask : t_serial
  task automatic t_pin_reset();
    int a, o;
    a = acts;
    o = offs;
    u_host_ctrl_model.reset_pulse(3, 1'b1);
    check(acts - a, 0);
    check(offs > o, 1'b1);
    u_host_ctrl_model.reset_pulse(12, 1'b0);
    check(acts - a, 0);
    u_host_ctrl_model.reset_pulse(12, 1'b1);
    check(acts > a, 1'b1);
    check(clocks_enable, 1'b1);
    @(posedge sys_clk) nvm_plan_valid <= 1'b0;
    u_host_ctrl_model.reset_pulse(12, 1'b1);
    check({in_bootloader, clocks_enable}, 2'b10);
    a = strobes;
    u_host_ctrl_model.download(3);
    cyc(3);
    check(strobes - a, 3);
    check({in_bootloader, clocks_enable}, 2'b01);
  endtask : t_pin_reset
  initial begin
    {rst_b, address_select_or_chip_select, address_select_driven, spi_mode} = 4'h0;
    {spi_four_wire, fast_rate, engine_busy, engine_sda_low} = 4'h0;
    {spi_read_data, spi_read_active, shared_data_out_or_aux_io_in} = 3'h0;
    {clk_en, nvm_plan_valid, general_io_in} = 5'h18;
    {io_dir_out, io_drive_value} = 8'h00;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_start(7'h68);
    @(posedge sys_clk) {address_select_or_chip_select, address_select_driven, rst_b} <= 3'b110;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_start(7'h69);
    t_serial();
    t_pin_reset();
    complete_run();
  end
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
endmodule : host_port_reset_boot_tb
bind host_port_reset_boot host_port_reset_boot_monitor #(
  .RST_MIN_CYCLES(RST_MIN_CYCLES),
  .IO_COUNT(IO_COUNT)
) u_mon (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .clk_en(clk_en),
  .device_reset_n(device_reset_n),
  .device_reset_n_driven(device_reset_n_driven),
  .scl_oe_n(scl_oe_n),
  .sda_oe_n(sda_oe_n),
  .spi_mode(spi_mode),
  .spi_four_wire(spi_four_wire),
  .fast_rate(fast_rate),
  .engine_busy(engine_busy),
  .engine_sda_low(engine_sda_low),
  .spi_read_data(spi_read_data),
  .spi_read_active(spi_read_active),
  .shared_data_out_or_aux_io_out(shared_data_out_or_aux_io_out),
  .shared_data_out_or_aux_io_oe_n(shared_data_out_or_aux_io_oe_n),
  .general_io_oe_n(general_io_oe_n),
  .io_dir_out(io_dir_out),
  .nvm_read_req(nvm_read_req),
  .nvm_read_ack(nvm_read_ack),
  .load_strobe(load_strobe),
  .host_load_valid(host_load_valid),
  .nvm_read_data(nvm_read_data),
  .load_data(load_data),
  .host_load_data(host_load_data),
  .in_bootloader(in_bootloader),
  .clocks_enable(clocks_enable),
  .device_reset_active(device_reset_active)
);
